// File: rtl/agu_consts.svh
// Behaviour
// - modulo wrap triggers on address above upper or below lower bound, not equality
// - corrected pointer written back only for pre/post modify; offset form keeps pointer
// - bit reversal exists only in the X write generator, for writes only
// - only the pivot modifier is reversed; pointer addresses stay in normal order
// - reversal active when select not 15, enable bit 15 set, pre/post increment
// - pivot is a 15-bit field in bits 14..0 of the reversal register
// - reversal assumes words: pivot scaled to bytes, address bit 0 forced clear
// - byte writes or other modes give ordinary addresses even when reversal enabled
// - during reversal the pointer adds the pivot; the mode's own step is ignored
// - reversal beats circular in X write generator; reads keep circular correction
// - a 16-entry buffer yields mirrored 4-bit indices, 1 to 8, 3 to 12
// - program words are 24 bits, data words 16 bits, alignment kept
// - table access address is 8-bit table page above 16-bit effective address
// - table page bit 7 picks user (0) or configuration (1) space
// - visibility access: page above low 15 address bits, 23 bits, user space only
// - visibility program address bit 15 comes from visibility page bit 0
// - visibility gives read-only low word access; table access reaches whole word
// - circular correction applies to any working register chosen as circular pointer
// - X circular active only when select not 15 and enable bit 15 set
// - visibility remap only when core control bit 2 is set
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH
// register byte offsets
`define AGU_OFS_CIRC 8'h00
`define AGU_OFS_XSTART 8'h04
`define AGU_OFS_XEND 8'h08
`define AGU_OFS_BREV 8'h0C
`define AGU_OFS_TPAGE 8'h10
`define AGU_OFS_VPAGE 8'h14
`define AGU_OFS_CORE 8'h18
`define AGU_OFS_STATUS 8'h1C
// field positions
`define AGU_XEN_BIT 15
`define AGU_XSEL_LSB 0
`define AGU_BSEL_LSB 8
`define AGU_REVERSAL_ENABLE_BIT 15
`define AGU_PSV_BIT 2
`define AGU_CFG_BIT 7
`define AGU_PIVOT_MSB 14
`define AGU_ST_BREV_BIT 16
`define AGU_ST_WRAP_BIT 17
// reset values and codes
`define AGU_CIRC_RST 16'h0FFF
`define AGU_WORD_RST 16'h0000
`define AGU_PAGE_RST 8'h00
`define AGU_PTR_NONE 4'hF
`endif

// File: rtl/agu_pkg.sv
package agu_pkg;
	// indirect addressing forms presented by the decoder
	typedef enum logic [2:0] {
		AM_INDIRECT,
		AM_POST_INC,
		AM_POST_DEC,
		AM_PRE_INC,
		AM_PRE_DEC,
		AM_REG_OFFSET
	} addr_mode_e;
	typedef logic [15:0] data_addr_t;
	typedef logic [23:0] prog_addr_t;
endpackage : agu_pkg

// File: rtl/bit_reverse_adder.sv
`timescale 1ns/10ps
// reverse-carry adder: mirror both operands, add, mirror back
module bit_reverse_adder #(
	parameter int WIDTH = 16
) (
	// operands
	input wire logic [WIDTH-1:0] base,
	input wire logic [WIDTH-2:0] pivot,
	// result, word aligned
	output logic [WIDTH-1:0] next
);
	logic [WIDTH-1:0] revBase;
	logic [WIDTH-1:0] revPivot;
	logic [WIDTH-1:0] revSum;
	logic [WIDTH-1:0] scaled;

	// pivot counts words, so shift to bytes
	assign scaled = {pivot, 1'b0};
	assign revSum = revBase + revPivot;
	// mirroring makes a normal add carry from msb toward lsb
	for (genvar i = 0; i < WIDTH; i++) begin : g_mirror
		assign revBase[i] = base[WIDTH-1-i];
		assign revPivot[i] = scaled[WIDTH-1-i];
		if (i == 0) begin : g_lsb
			assign next[i] = 1'b0;
		end else begin : g_bit
			assign next[i] = revSum[WIDTH-1-i];
		end
	end
endmodule : bit_reverse_adder

// File: rtl/address_generation_unit.sv
`timescale 1ns/10ps
`include "agu_consts.svh"
module address_generation_unit
	import agu_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// request from the instruction decoder
	input wire logic reqValid,
	input wire logic [3:0] reqPtrSel,
	input wire logic [15:0] reqPtr,
	input wire addr_mode_e reqMode,
	input wire logic [15:0] reqOffset,
	input wire logic reqWrite,
	input wire logic reqByte,
	input wire logic reqTable,
	// data address and pointer write-back
	output logic addrValid,
	output logic [15:0] effAddr,
	output logic wbValid,
	output logic [3:0] wbSel,
	output logic [15:0] wbValue,
	output logic brevApplied,
	output logic modWrapped,
	// program space access
	output logic progValid,
	output logic [23:0] progAddr,
	output logic progConfig,
	output logic progReadOnly
);
	logic [1:0] rstSync_q;
	logic rstSyncN;
	logic [15:0] circ_q;
	logic [15:0] xStart_q;
	logic [15:0] xEnd_q;
	logic [15:0] brev_q;
	logic [7:0] tablePage_q;
	logic [7:0] visPage_q;
	logic [15:0] core_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic addrValid_q;
	data_addr_t effAddr_q;
	logic wbValid_q;
	logic [3:0] wbSel_q;
	data_addr_t wbValue_q;
	logic brevApplied_q;
	logic modWrapped_q;
	logic progValid_q;
	prog_addr_t progAddr_q;
	logic progConfig_q;
	logic progReadOnly_q;
	logic apbSetup;
	logic apbWrite;
	logic [31:0] rdData_d;
	logic addrHit_d;
	logic [15:0] byteMask;
	logic [3:0] xSel;
	logic [3:0] bSel;
	logic isInc;
	logic isPre;
	logic isPost;
	logic decDir;
	data_addr_t raw;
	data_addr_t modLen;
	logic modActive;
	logic wrapUp;
	logic wrapDown;
	data_addr_t corrected;
	logic brevHit;
	data_addr_t brevNext;
	data_addr_t nextPtr;
	data_addr_t ea_d;
	logic psvHit;

	// reset released through two flops so release is clean in this domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_q <= 2'b00;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstSyncN = rstSync_q[1];

	// apb phases; answer is prepared in setup so access takes one cycle
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pwrite && pready_q && !pslverr_q;
	assign byteMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// read mux and address decode
	always_comb begin
		rdData_d = 32'h0000_0000;
		addrHit_d = 1'b1;
		case (paddr)
			`AGU_OFS_CIRC: rdData_d[15:0] = circ_q;
			`AGU_OFS_XSTART: rdData_d[15:0] = xStart_q;
			`AGU_OFS_XEND: rdData_d[15:0] = xEnd_q;
			`AGU_OFS_BREV: rdData_d[15:0] = brev_q;
			`AGU_OFS_TPAGE: rdData_d[7:0] = tablePage_q;
			`AGU_OFS_VPAGE: rdData_d[7:0] = visPage_q;
			`AGU_OFS_CORE: rdData_d[15:0] = core_q;
			`AGU_OFS_STATUS: begin
				rdData_d[15:0] = effAddr_q;
				rdData_d[`AGU_ST_BREV_BIT] = brevApplied_q;
				rdData_d[`AGU_ST_WRAP_BIT] = modWrapped_q;
			end
			default: addrHit_d = 1'b0;
		endcase
	end

	// bus answer registers; unmapped addresses answer with pslverr
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apbSetup;
			pslverr_q <= apbSetup && !addrHit_d;
			if (apbSetup && !pwrite) begin
				prdata_q <= rdData_d;
			end
		end
	end

	// software registers, byte lanes honoured; status is read only
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			circ_q <= `AGU_CIRC_RST;
			xStart_q <= `AGU_WORD_RST;
			xEnd_q <= `AGU_WORD_RST;
			brev_q <= `AGU_WORD_RST;
			tablePage_q <= `AGU_PAGE_RST;
			visPage_q <= `AGU_PAGE_RST;
			core_q <= `AGU_WORD_RST;
		end else if (apbWrite) begin
			case (paddr)
				`AGU_OFS_CIRC: circ_q <= (circ_q & ~byteMask) | (pwdata[15:0] & byteMask);
				`AGU_OFS_XSTART: xStart_q <= (xStart_q & ~byteMask) | (pwdata[15:0] & byteMask);
				`AGU_OFS_XEND: xEnd_q <= (xEnd_q & ~byteMask) | (pwdata[15:0] & byteMask);
				`AGU_OFS_BREV: brev_q <= (brev_q & ~byteMask) | (pwdata[15:0] & byteMask);
				`AGU_OFS_TPAGE: begin
					if (pstrb[0]) begin
						tablePage_q <= pwdata[7:0];
					end
				end
				`AGU_OFS_VPAGE: begin
					if (pstrb[0]) begin
						visPage_q <= pwdata[7:0];
					end
				end
				`AGU_OFS_CORE: core_q <= (core_q & ~byteMask) | (pwdata[15:0] & byteMask);
				default: ;
			endcase
		end
	end

	// mode decode
	assign xSel = circ_q[`AGU_XSEL_LSB +: 4];
	assign bSel = circ_q[`AGU_BSEL_LSB +: 4];
	assign isInc = (reqMode == AM_PRE_INC) || (reqMode == AM_POST_INC);
	assign isPre = (reqMode == AM_PRE_INC) || (reqMode == AM_PRE_DEC);
	assign isPost = (reqMode == AM_POST_INC) || (reqMode == AM_POST_DEC);
	// offset form direction follows the sign of the offset
	assign decDir = (reqMode == AM_PRE_DEC) || (reqMode == AM_POST_DEC)
		|| ((reqMode == AM_REG_OFFSET) && reqOffset[15]);

	// raw modified address before any correction
	always_comb begin
		case (reqMode)
			AM_POST_INC, AM_PRE_INC, AM_REG_OFFSET: raw = reqPtr + reqOffset;
			AM_POST_DEC, AM_PRE_DEC: raw = reqPtr - reqOffset;
			default: raw = reqPtr;
		endcase
	end

	// reversal only for word writes through the chosen pointer, pre/post increment
	assign brevHit = brev_q[`AGU_REVERSAL_ENABLE_BIT] && (bSel != `AGU_PTR_NONE)
		&& (reqPtrSel == bSel) && reqWrite && !reqByte && isInc;

	bit_reverse_adder #(
		.WIDTH(16)
	) u_brev (
		.base(reqPtr),
		.pivot(brev_q[`AGU_PIVOT_MSB:0]),
		.next(brevNext)
	);

	// circular correction on any selected pointer; reversal disables it for writes
	assign modActive = circ_q[`AGU_XEN_BIT] && (xSel != `AGU_PTR_NONE)
		&& (reqPtrSel == xSel) && !brevHit;
	assign modLen = xEnd_q - xStart_q + 16'h0001;
	// magnitude compares catch steps that jump past the bound
	assign wrapUp = modActive && !decDir && (raw > xEnd_q);
	assign wrapDown = modActive && decDir && (raw < xStart_q);
	always_comb begin
		if (wrapUp) begin
			corrected = raw - modLen;
		end else if (wrapDown) begin
			corrected = raw + modLen;
		end else begin
			corrected = raw;
		end
	end

	// reversal replaces the mode step entirely
	assign nextPtr = brevHit ? brevNext : corrected;

	// effective address per form; reversed post uses the word-aligned pointer
	always_comb begin
		if (isPre) begin
			ea_d = nextPtr;
		end else if (reqMode == AM_REG_OFFSET) begin
			ea_d = corrected;
		end else if (brevHit) begin
			ea_d = {reqPtr[15:1], 1'b0};
		end else begin
			ea_d = reqPtr;
		end
	end

	// visibility remap: reads only, top ea bit set, enable bit in core control
	assign psvHit = !reqTable && !reqWrite && core_q[`AGU_PSV_BIT] && ea_d[15];

	// data side answer, one cycle after the request
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			addrValid_q <= 1'b0;
			effAddr_q <= `AGU_WORD_RST;
			brevApplied_q <= 1'b0;
			modWrapped_q <= 1'b0;
		end else begin
			addrValid_q <= reqValid;
			if (reqValid) begin
				effAddr_q <= ea_d;
				brevApplied_q <= brevHit;
				modWrapped_q <= wrapUp || wrapDown;
			end
		end
	end

	// pointer write-back only for pre and post modify forms
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			wbValid_q <= 1'b0;
			wbSel_q <= 4'h0;
			wbValue_q <= `AGU_WORD_RST;
		end else begin
			wbValid_q <= reqValid && (isPre || isPost);
			if (reqValid) begin
				wbSel_q <= reqPtrSel;
				wbValue_q <= nextPtr;
			end
		end
	end

	// program space address: 24-bit table form or 23-bit visibility form
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			progValid_q <= 1'b0;
			progAddr_q <= 24'h00_0000;
			progConfig_q <= 1'b0;
			progReadOnly_q <= 1'b0;
		end else begin
			progValid_q <= reqValid && (reqTable || psvHit);
			if (reqValid && reqTable) begin
				progAddr_q <= {tablePage_q, ea_d};
				progConfig_q <= tablePage_q[`AGU_CFG_BIT];
				progReadOnly_q <= 1'b0;
			end else if (reqValid && psvHit) begin
				// page bit 0 lands on address bit 15; ea bit 15 is dropped
				progAddr_q <= {1'b0, visPage_q, ea_d[14:0]};
				progConfig_q <= 1'b0;
				progReadOnly_q <= 1'b1;
			end
		end
	end

	// outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign addrValid = addrValid_q;
	assign effAddr = effAddr_q;
	assign wbValid = wbValid_q;
	assign wbSel = wbSel_q;
	assign wbValue = wbValue_q;
	assign brevApplied = brevApplied_q;
	assign modWrapped = modWrapped_q;
	assign progValid = progValid_q;
	assign progAddr = progAddr_q;
	assign progConfig = progConfig_q;
	assign progReadOnly = progReadOnly_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSyncN);

	sequence s_apb_setup;
		psel && !penable;
	endsequence
	sequence s_brev_req;
		reqValid && brevHit;
	endsequence

	a_apb_one_wait: assert property (s_apb_setup |=> pready ##1 !pready)
		else $error("apb answer not exactly one access cycle");
	a_brev_word_addr: assert property (s_brev_req |=>
		brevApplied && !effAddr[0] && !modWrapped)
		else $error("reversed address not word aligned or wrapped");
	a_brev_byte_off: assert property (reqValid && reqByte |=> !brevApplied)
		else $error("reversal applied to a byte access");
	a_brev_read_off: assert property (reqValid && !reqWrite |=> !brevApplied)
		else $error("reversal applied to a read");
	a_brev_gate: assert property (reqValid && brevHit |->
		brev_q[`AGU_REVERSAL_ENABLE_BIT] && bSel != `AGU_PTR_NONE && isInc)
		else $error("reversal active without its enables");
	a_brev_step: assert property (s_brev_req ##0 (reqMode == AM_PRE_INC) |=>
		wbValue == effAddr)
		else $error("reversed pre-increment disagrees with write-back");
	a_mod_upper: assert property (reqValid && wrapUp && isPre |=>
		wbValue == $past(raw) - $past(modLen))
		else $error("upper wrap not corrected by buffer length");
	a_wb_offset: assert property (reqValid && reqMode == AM_REG_OFFSET |=> !wbValid)
		else $error("offset form wrote the pointer back");
	a_mod_read_kept: assert property (reqValid && !reqWrite && circ_q[`AGU_XEN_BIT]
		&& xSel != `AGU_PTR_NONE && reqPtrSel == xSel |-> modActive)
		else $error("circular correction lost on a read");
	a_table_concat: assert property (reqValid && reqTable |=>
		progValid && progAddr == {$past(tablePage_q), effAddr})
		else $error("table address not page over ea");
	a_table_space: assert property (progValid && !progReadOnly |-> progConfig == progAddr[23])
		else $error("table space select mismatch");
	a_psv_form: assert property (progValid && progReadOnly |->
		!progAddr[23] && progAddr[14:0] == effAddr[14:0])
		else $error("visibility address malformed");
	// the read-only flag holds over requests without a program access, so pair it with the valid
	a_psv_read_only: assert property (reqValid && reqWrite |=> !(progValid && progReadOnly))
		else $error("visibility used for a write");
	a_psv_enable: assert property (reqValid && !reqTable && !core_q[`AGU_PSV_BIT] |=>
		!progValid)
		else $error("visibility remap while disabled");
endmodule : address_generation_unit

// File: tb/decoder_model.sv
`timescale 1ns/10ps
// stands in for the instruction decoder and register file on the request side
module decoder_model
	import agu_pkg::*;
(
	// clock
	input wire logic clk,
	// request to the address generator
	output logic reqValid,
	output logic [3:0] reqPtrSel,
	output logic [15:0] reqPtr,
	output addr_mode_e reqMode,
	output logic [15:0] reqOffset,
	output logic reqWrite,
	output logic reqByte,
	output logic reqTable
);
	// quiet at time zero
	initial begin
		reqValid = 1'b0;
		reqPtrSel = 4'h0;
		reqPtr = 16'h0000;
		reqMode = AM_INDIRECT;
		reqOffset = 16'h0000;
		reqWrite = 1'b0;
		reqByte = 1'b0;
		reqTable = 1'b0;
	end

	// one request, then pointer and offset lines flip so a stale value can never pass as held
	task automatic send(input logic [3:0] sel, input logic [15:0] ptr, input addr_mode_e mode,
		input logic [15:0] ofs, input logic wr, input logic byt, input logic tbl);
		@(posedge clk);
		reqValid <= 1'b1;
		reqPtrSel <= sel;
		reqPtr <= ptr;
		reqMode <= mode;
		reqOffset <= ofs;
		reqWrite <= wr;
		reqByte <= byt;
		reqTable <= tbl;
		@(posedge clk);
		reqValid <= 1'b0;
		reqPtr <= ~ptr;
		reqOffset <= ~ofs;
		// answers are one-cycle pulses, look in the middle of that cycle
		@(negedge clk);
	endtask : send
endmodule : decoder_model

// File: tb/address_generation_unit_test.sv
`timescale 1ns/10ps
`include "agu_consts.svh"
module address_generation_unit_test
	import agu_pkg::*;
;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0] pstrb;
	logic err;
	logic reqValid, reqWrite, reqByte, reqTable;
	logic [3:0] reqPtrSel, wbSel;
	logic [15:0] reqPtr, reqOffset, effAddr, wbValue;
	addr_mode_e reqMode;
	logic addrValid, wbValid, brevApplied, modWrapped, progValid, progConfig, progReadOnly;
	logic [23:0] progAddr;
	int nFail = 0;
	int numChecks = 0;

	address_generation_unit i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reqValid(reqValid), .reqPtrSel(reqPtrSel),
		.reqPtr(reqPtr), .reqMode(reqMode), .reqOffset(reqOffset), .reqWrite(reqWrite),
		.reqByte(reqByte), .reqTable(reqTable), .addrValid(addrValid), .effAddr(effAddr),
		.wbValid(wbValid), .wbSel(wbSel), .wbValue(wbValue), .brevApplied(brevApplied),
		.modWrapped(modWrapped), .progValid(progValid), .progAddr(progAddr),
		.progConfig(progConfig), .progReadOnly(progReadOnly));

	decoder_model decoder (.clk(clk), .reqValid(reqValid), .reqPtrSel(reqPtrSel),
		.reqPtr(reqPtr), .reqMode(reqMode), .reqOffset(reqOffset), .reqWrite(reqWrite),
		.reqByte(reqByte), .reqTable(reqTable));

	// 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic conclude;
		if (nFail == 0 && numChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chkFlag(input logic got, input logic exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkFlag

	// apb transfer; request held until the rising edge that sees pready, data taken there
	task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apbXfer

	function automatic logic [3:0] rev4(input logic [3:0] v);
		return {v[0], v[1], v[2], v[3]};
	endfunction : rev4

	task automatic testRegs;
		apbXfer(1'b0, `AGU_OFS_CIRC, 16'h0000);
		chk(rdat, 32'h0000_0FFF);
		apbXfer(1'b1, `AGU_OFS_BREV, 16'h7FFF);
		apbXfer(1'b0, `AGU_OFS_BREV, 16'h0000);
		chk(rdat, 32'h0000_7FFF);
		apbXfer(1'b0, 8'h20, 16'h0000);
		chkFlag(err, 1'b1);
		chk(rdat, 32'h0000_0000);
	endtask : testRegs

	task automatic testPlain;
		decoder.send(4'h1, 16'h1000, AM_PRE_INC, 16'h0002, 1'b1, 1'b0, 1'b0);
		chkFlag(addrValid, 1'b1);
		chk(effAddr, 32'h1002);
		chkFlag(wbValid, 1'b1);
		chk(wbSel, 32'h1);
		chk(wbValue, 32'h1002);
		decoder.send(4'h1, 16'h2000, AM_INDIRECT, 16'h0002, 1'b0, 1'b0, 1'b0);
		chk(effAddr, 32'h2000);
		chkFlag(wbValid, 1'b0);
	endtask : testPlain

	task automatic testCircular;
		apbXfer(1'b1, `AGU_OFS_XSTART, 16'h1000);
		apbXfer(1'b1, `AGU_OFS_XEND, 16'h100F);
		apbXfer(1'b1, `AGU_OFS_CIRC, 16'h8F02);
		// step of 4 jumps past the end, not onto it
		decoder.send(4'h2, 16'h100E, AM_POST_INC, 16'h0004, 1'b0, 1'b0, 1'b0);
		chk(effAddr, 32'h100E);
		chk(wbValue, 32'h1002);
		chkFlag(modWrapped, 1'b1);
		decoder.send(4'h2, 16'h1002, AM_PRE_DEC, 16'h0004, 1'b1, 1'b0, 1'b0);
		chk(effAddr, 32'h100E);
		chk(wbValue, 32'h100E);
		decoder.send(4'h2, 16'h100E, AM_REG_OFFSET, 16'h0004, 1'b0, 1'b0, 1'b0);
		chk(effAddr, 32'h1002);
		chkFlag(wbValid, 1'b0);
		decoder.send(4'h5, 16'h100E, AM_POST_INC, 16'h0004, 1'b0, 1'b0, 1'b0);
		chk(wbValue, 32'h1012);
		apbXfer(1'b1, `AGU_OFS_CIRC, 16'h0F02);
		decoder.send(4'h2, 16'h100E, AM_POST_INC, 16'h0004, 1'b0, 1'b0, 1'b0);
		chk(wbValue, 32'h1012);
		chkFlag(modWrapped, 1'b0);
	endtask : testCircular

	task automatic testBrev;
		logic [15:0] p;
		// circular also on w3 with a tiny buffer, so any leak of it would show
		apbXfer(1'b1, `AGU_OFS_XEND, 16'h1003);
		apbXfer(1'b1, `AGU_OFS_CIRC, 16'h8303);
		apbXfer(1'b1, `AGU_OFS_BREV, 16'h8008);
		repeat (2) @(posedge clk);
		// 16-word buffer at 0x1000, low five bits clear
		for (int k = 0; k < 16; k++) begin
			p = 16'h1000 | {11'h000, rev4(k[3:0]), 1'b0};
			decoder.send(4'h3, p, AM_POST_INC, 16'h0002, 1'b1, 1'b0, 1'b0);
			chk(effAddr, {16'h0000, p});
			chk(wbValue, 32'h1000 | {27'h0, rev4(k[3:0] + 4'h1), 1'b0});
			chkFlag(brevApplied, 1'b1);
		end
		decoder.send(4'h3, 16'h1000, AM_PRE_INC, 16'h0006, 1'b1, 1'b0, 1'b0);
		chk(effAddr, 32'h1010);
		decoder.send(4'h3, 16'h1000, AM_POST_INC, 16'h0001, 1'b1, 1'b1, 1'b0);
		chk(wbValue, 32'h1001);
		chkFlag(brevApplied, 1'b0);
		decoder.send(4'h3, 16'h1002, AM_POST_INC, 16'h0002, 1'b0, 1'b0, 1'b0);
		chk(wbValue, 32'h1000);
		chkFlag(brevApplied, 1'b0);
		decoder.send(4'h3, 16'h1002, AM_PRE_DEC, 16'h0002, 1'b1, 1'b0, 1'b0);
		chk(effAddr, 32'h1000);
		chkFlag(brevApplied, 1'b0);
	endtask : testBrev

	task automatic testProg;
		apbXfer(1'b1, `AGU_OFS_TPAGE, 16'h0085);
		decoder.send(4'h4, 16'h1234, AM_INDIRECT, 16'h0000, 1'b0, 1'b0, 1'b1);
		chkFlag(progValid, 1'b1);
		chk(progAddr, 32'h85_1234);
		chkFlag(progConfig, 1'b1);
		apbXfer(1'b1, `AGU_OFS_TPAGE, 16'h0005);
		decoder.send(4'h4, 16'h1234, AM_INDIRECT, 16'h0000, 1'b1, 1'b0, 1'b1);
		chk(progAddr, 32'h05_1234);
		chkFlag(progConfig, 1'b0);
		apbXfer(1'b1, `AGU_OFS_VPAGE, 16'h00A5);
		decoder.send(4'h4, 16'h8123, AM_INDIRECT, 16'h0000, 1'b0, 1'b0, 1'b0);
		chkFlag(progValid, 1'b0);
		apbXfer(1'b1, `AGU_OFS_CORE, 16'h0004);
		decoder.send(4'h4, 16'h8123, AM_INDIRECT, 16'h0000, 1'b0, 1'b0, 1'b0);
		chkFlag(progValid, 1'b1);
		chk(progAddr, 32'h52_8123);
		chkFlag(progReadOnly, 1'b1);
		decoder.send(4'h4, 16'h8123, AM_INDIRECT, 16'h0000, 1'b1, 1'b0, 1'b0);
		chkFlag(progValid, 1'b0);
		// table access with the top ea bit set still uses the table page
		decoder.send(4'h4, 16'h8123, AM_INDIRECT, 16'h0000, 1'b0, 1'b0, 1'b1);
		chk(progAddr, 32'h05_8123);
		chkFlag(progReadOnly, 1'b0);
	endtask : testProg

	// main sequence
	initial begin
		rst_n <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		pstrb <= 4'h3;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		testRegs();
		testPlain();
		testCircular();
		testBrev();
		testProg();
		conclude();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		nFail++;
		conclude();
	end
endmodule : address_generation_unit_test
